// *** design/sbc_status_map.svh ***
// constants of the status readback register group
// assumes inclusion by bare name from design files
//
// Summary of operation
// - level register at 0x48, read only
// - level bit 7 returns test pin
// - level bit 6 always reads one
// - level bit 5 mirrors fail-output configuration
// - level bit 0 returns wake input
// - other reserved bits read zero, level bit 6 reads one
// - level register reset patterns per reset kind
// - regulator register at 0x4c, clear on read
// - upper nibble cleared soft, kept restart
// - bit 7 boost has been active
// - bit 6 boost drain/sense short
// - bit 5 OR of three open detections
// - bit 4 boost gate short
// - bit 2 buck switch short
// - bit 1 buck switch open
// - bit 0 main output out of range
// - identification register at 0x7e, read only
`ifndef SBC_STATUS_MAP_SVH
`define SBC_STATUS_MAP_SVH

`define ADDR_INPUT_LEVEL_STATUS      7'h48
`define ADDR_REGULATOR_FAULT_STATUS  7'h4c
`define ADDR_PART_IDENTIFICATION     7'h7e

`define LVL_TEST_BIT                 7
`define LVL_RESERVED_ONE_BIT         6
`define LVL_CFG_MIRROR_BIT           5
`define LVL_WAKE_BIT                 0

`define REG_BOOST_ACTIVE_BIT         7
`define REG_BOOST_SHORT_BIT          6
`define REG_BOOST_OPEN_BIT           5
`define REG_BOOST_GATE_SHORT_BIT     4
`define REG_RESERVED_ZERO_BIT        3
`define REG_BUCK_SHORT_BIT           2
`define REG_BUCK_OPEN_BIT            1
`define REG_RANGE_BIT                0

`define REG_NUM_FLAGS                7
`define REG_NUM_KEPT_FLAGS           4

`define READ_DATA_RESET              8'h00
`define CFG_MIRROR_RESET             1'b0

`endif

// *** design/sbc_status_pkg.sv ***
// types shared by the status readback register group
// assumes nothing beyond a SystemVerilog compiler
package sbc_status_pkg;

   typedef enum logic [1:0] {
      SEL_LEVEL,
      SEL_REGULATOR,
      SEL_IDENT,
      SEL_NONE
   } reg_sel_t;

endpackage : sbc_status_pkg

// *** design/clear_on_read_flag.sv ***
// one latched fault flag with clear on read and reset preload
// assumes condition, clear and preload are synchronous to clock_i
`timescale 1ns/1ps
`default_nettype none

module clear_on_read_flag (
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic cond_i,
   input  wire logic clear_i,
   input  wire logic preload_i,
   input  wire logic preload_val_i,
   output var  logic flag_o
);

   typedef struct packed {
      logic flag_ff;
   } flag_state_t;

   flag_state_t state_ff;
   flag_state_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      if (preload_i) begin
         nxt_state.flag_ff = preload_val_i;
      end else begin
         // set wins over the read clear
         nxt_state.flag_ff = cond_i | (state_ff.flag_ff & ~clear_i);
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign flag_o = state_ff.flag_ff;

endmodule : clear_on_read_flag

`default_nettype wire

// *** design/sbc_status_readback_regs.sv ***
// read-only status registers and clear-on-read regulator faults
// assumes the serial frame logic issues one-cycle read strobes with a 7-bit address
`timescale 1ns/1ps
`default_nettype none
`include "sbc_status_map.svh"

module sbc_status_readback_regs #(
   parameter logic [3:0] PRODUCT_LINE_CODE = 4'h3, // arbitrary value
   parameter logic [3:0] VARIANT_CODE      = 4'h6  // arbitrary value
) (
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       soft_reset_i,
   input  wire logic       restart_i,
   input  wire logic       rd_en_i,
   input  wire logic [6:0] rd_addr_i,
   input  wire logic       test_pin_i,
   input  wire logic       wake_input_level_i,
   input  wire logic       fail_output_config_bit_i,
   input  wire logic       boost_active_i,
   input  wire logic       boost_drain_short_i,
   input  wire logic       boost_sense_short_i,
   input  wire logic       boost_diode_lost_i,
   input  wire logic       boost_resistor_lost_i,
   input  wire logic       boost_sense_gnd_lost_i,
   input  wire logic       boost_gate_short_i,
   input  wire logic       buck_switch_short_i,
   input  wire logic       buck_switch_open_i,
   input  wire logic       main_output_out_of_range_i,
   output var  logic [7:0] rd_data_o,
   output var  logic       rd_valid_o,
   output var  logic       rd_hit_o
);

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   function automatic sbc_status_pkg::reg_sel_t decode_addr(input logic [6:0] addr);
      sbc_status_pkg::reg_sel_t sel;
      sel = sbc_status_pkg::SEL_NONE;
      if (addr == `ADDR_INPUT_LEVEL_STATUS) begin
         sel = sbc_status_pkg::SEL_LEVEL;
      end else if (addr == `ADDR_REGULATOR_FAULT_STATUS) begin
         sel = sbc_status_pkg::SEL_REGULATOR;
      end else if (addr == `ADDR_PART_IDENTIFICATION) begin
         sel = sbc_status_pkg::SEL_IDENT;
      end
      return sel;
   endfunction : decode_addr

   ////////////////////////////////////////////////////////////////////////////
   // regulator fault flags

   logic [`REG_NUM_FLAGS-1:0] cond;
   logic [`REG_NUM_FLAGS-1:0] flags;
   logic [`REG_NUM_FLAGS-1:0] preload;
   logic [`REG_NUM_FLAGS-1:0] preload_val;
   logic                      reg_read;

   always_comb begin
      cond                           = '0;
      cond[`REG_BOOST_ACTIVE_BIT-1]  = boost_active_i;
      cond[`REG_BOOST_SHORT_BIT-1]   = boost_drain_short_i | boost_sense_short_i;
      cond[`REG_BOOST_OPEN_BIT-1]    = boost_diode_lost_i | boost_resistor_lost_i
                                       | boost_sense_gnd_lost_i;
      cond[`REG_BOOST_GATE_SHORT_BIT-1] = boost_gate_short_i;
      cond[`REG_BUCK_SHORT_BIT]      = buck_switch_short_i;
      cond[`REG_BUCK_OPEN_BIT]       = buck_switch_open_i;
      cond[`REG_RANGE_BIT]           = main_output_out_of_range_i;
   end

   assign reg_read = rd_en_i && (decode_addr(rd_addr_i) == sbc_status_pkg::SEL_REGULATOR);

   // flags index: 6..3 upper nibble, 2..0 lower three
   genvar gi;
   generate
      for (gi = 0; gi < `REG_NUM_FLAGS; gi++) begin : g_flag
         if (gi >= `REG_NUM_FLAGS - `REG_NUM_KEPT_FLAGS) begin : g_upper
            // kept across restart, cleared by soft reset
            assign preload[gi]     = soft_reset_i;
            assign preload_val[gi] = 1'b0;
         end else begin : g_lower
            // follows the live condition after either reset
            assign preload[gi]     = soft_reset_i | restart_i;
            assign preload_val[gi] = cond[gi];
         end
         clear_on_read_flag u_flag (
            .clock_i       (clock_i),
            .rst_i         (rst_i),
            .cond_i        (cond[gi]),
            .clear_i       (reg_read),
            .preload_i     (preload[gi]),
            .preload_val_i (preload_val[gi]),
            .flag_o        (flags[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic       test_ff;
      logic       wake_ff;
      logic       cfg_mirror_ff;
      logic [7:0] rd_data_ff;
      logic       rd_valid_ff;
      logic       rd_hit_ff;
   } regs_state_t;

   regs_state_t state_ff;
   regs_state_t nxt_state;
   logic [7:0]  level_word;
   logic [7:0]  regulator_word;
   logic [7:0]  ident_word;

   always_comb begin
      level_word                          = 8'h00;
      level_word[`LVL_TEST_BIT]           = state_ff.test_ff;
      level_word[`LVL_RESERVED_ONE_BIT]   = 1'b1;
      level_word[`LVL_CFG_MIRROR_BIT]     = state_ff.cfg_mirror_ff;
      level_word[`LVL_WAKE_BIT]           = state_ff.wake_ff;
      regulator_word = {flags[`REG_NUM_FLAGS-1:3], 1'b0, flags[2:0]};
      ident_word     = {PRODUCT_LINE_CODE, VARIANT_CODE};
   end

   always_comb begin
      nxt_state         = state_ff;
      nxt_state.test_ff = test_pin_i;
      nxt_state.wake_ff = wake_input_level_i;
      if (soft_reset_i) begin
         // soft reset pattern x100 000x, restart keeps the mirror live
         nxt_state.cfg_mirror_ff = `CFG_MIRROR_RESET;
      end else begin
         nxt_state.cfg_mirror_ff = fail_output_config_bit_i;
      end
      nxt_state.rd_valid_ff = rd_en_i;
      nxt_state.rd_hit_ff   = 1'b0;
      if (rd_en_i) begin
         nxt_state.rd_hit_ff = (decode_addr(rd_addr_i) != sbc_status_pkg::SEL_NONE);
         case (decode_addr(rd_addr_i))
            sbc_status_pkg::SEL_LEVEL:     nxt_state.rd_data_ff = level_word;
            sbc_status_pkg::SEL_REGULATOR: nxt_state.rd_data_ff = regulator_word;
            sbc_status_pkg::SEL_IDENT:     nxt_state.rd_data_ff = ident_word;
            default:                       nxt_state.rd_data_ff = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign rd_data_o  = state_ff.rd_data_ff;
   assign rd_valid_o = state_ff.rd_valid_ff;
   assign rd_hit_o   = state_ff.rd_hit_ff;

endmodule : sbc_status_readback_regs

`default_nettype wire

// *** sim/sbc_status_chk.sv ***
// assertions on the status readback ports
// assumes binding onto the design top, one clock
`timescale 1ns/1ps
`default_nettype none
module sbc_status_chk #(
   parameter logic [3:0] PRODUCT_LINE_CODE = 4'h3,
   parameter logic [3:0] VARIANT_CODE      = 4'h6
) (
   input wire logic       clock_i, rst_i, soft_reset_i, restart_i, rd_en_i,
   input wire logic [6:0] rd_addr_i,
   input wire logic       test_pin_i, wake_input_level_i, fail_output_config_bit_i,
   input wire logic       boost_diode_lost_i, boost_resistor_lost_i, boost_sense_gnd_lost_i,
   input wire logic       boost_gate_short_i, main_output_out_of_range_i,
   input wire logic [7:0] rd_data_o,
   input wire logic       rd_valid_o, rd_hit_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   wire lv  = rd_en_i && rd_addr_i == 7'h48;
   wire rg  = rd_en_i && rd_addr_i == 7'h4c;
   wire id  = rd_en_i && rd_addr_i == 7'h7e;
   wire hit = lv || rg || id;
   wire op  = boost_diode_lost_i || boost_resistor_lost_i || boost_sense_gnd_lost_i;
   a_valid_after_read: assert property (rd_en_i |=> rd_valid_o && rd_hit_o == $past(hit))
      else $error("read answer missing");
   a_valid_single: assert property (!rd_en_i |=> !rd_valid_o && !rd_hit_o)
      else $error("answer without read");
   a_level_fixed: assert property (lv |=> rd_data_o[6] && rd_data_o[4:1] == 4'h0)
      else $error("level fixed bits wrong");
   a_level_pins: assert property (lv && $stable(test_pin_i) && $stable(wake_input_level_i) && !$past(rst_i)
      |=> rd_data_o[7] == $past(test_pin_i) && rd_data_o[0] == $past(wake_input_level_i))
      else $error("level pin bits wrong");
   a_mirror_cfg: assert property (lv && $stable(fail_output_config_bit_i) && !soft_reset_i
      && !$past(soft_reset_i) && !$past(rst_i) |=> rd_data_o[5] == $past(fail_output_config_bit_i))
      else $error("mirror bit wrong");
   a_soft_mirror: assert property (lv && $past(soft_reset_i) |=> !rd_data_o[5])
      else $error("mirror not cleared by soft reset");
   a_ident_code: assert property (id |=> rd_data_o == {PRODUCT_LINE_CODE, VARIANT_CODE})
      else $error("identification wrong");
   a_unmapped_zero: assert property (rd_en_i && !hit |=> rd_data_o == 8'h00)
      else $error("unmapped read not zero");
   a_reg_bit3: assert property (rg |=> !rd_data_o[3])
      else $error("regulator bit 3 set");
   a_range_latch: assert property (rg && $past(main_output_out_of_range_i) && !$past(rst_i) |=> rd_data_o[0])
      else $error("range flag not latched");
   a_open_or: assert property (rg && $past(op) && !$past(soft_reset_i) && !$past(rst_i) |=> rd_data_o[5])
      else $error("open flag not latched");
   a_gate_clear: assert property (rg && !boost_gate_short_i && !restart_i ##1 rg |=> !rd_data_o[4])
      else $error("flag not cleared by read");
endmodule : sbc_status_chk
bind sbc_status_readback_regs sbc_status_chk #(.PRODUCT_LINE_CODE(PRODUCT_LINE_CODE),
   .VARIANT_CODE(VARIANT_CODE)) chk (.*);
`default_nettype wire

// *** sim/host_read_model.sv ***
// host side issuing register read strobes
// assumes its tasks are called in sequence by the bench
`timescale 1ns/1ps
`default_nettype none
module host_read_model (
   input  wire logic       clock_i,
   output var  logic       rd_en_o,
   output var  logic [6:0] rd_addr_o
);
   initial begin
      rd_en_o = 1'b0;
      rd_addr_o = 7'h00;
   end
   // one read per edge while held; host reads to acknowledge faults
   task automatic read(input logic [6:0] a);
      @(posedge clock_i);
      #1;
      rd_en_o = 1'b1;
      rd_addr_o = a;
   endtask : read
   task automatic idle();
      @(posedge clock_i);
      #1;
      rd_en_o = 1'b0;
      rd_addr_o = ~rd_addr_o;
   endtask : idle
endmodule : host_read_model
`default_nettype wire

// *** sim/sbc_status_readback_regs_tb_top.sv ***
// self-checking bench for the status readback registers
// assumes the host model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module sbc_status_readback_regs_tb_top;
   localparam logic [3:0] PL = 4'ha; // arbitrary value
   localparam logic [3:0] VC = 4'h7; // arbitrary value
   logic       clock_i = 1'b0, rst_i = 1'b1, soft_reset_i = 1'b0, restart_i = 1'b0;
   logic       test_pin_i = 1'b0, wake_i = 1'b0, cfg_i = 1'b0, rd_en, rd_valid_o, rd_hit_o;
   logic [9:0] cond = 10'h000;
   logic [6:0] rd_addr;
   logic [7:0] rd_data_o;
   logic [8:0] exp_q[$];
   int         bad_count = 0;
   int         compares = 0;
   int         bit_of[10] = '{0, 1, 2, 4, 5, 5, 5, 6, 6, 7};
   sbc_status_readback_regs #(.PRODUCT_LINE_CODE(PL), .VARIANT_CODE(VC)) dut (
      .clock_i(clock_i), .rst_i(rst_i), .soft_reset_i(soft_reset_i), .restart_i(restart_i),
      .rd_en_i(rd_en), .rd_addr_i(rd_addr), .test_pin_i(test_pin_i), .wake_input_level_i(wake_i),
      .fail_output_config_bit_i(cfg_i), .boost_active_i(cond[9]), .boost_drain_short_i(cond[7]),
      .boost_sense_short_i(cond[8]), .boost_diode_lost_i(cond[4]), .boost_resistor_lost_i(cond[5]),
      .boost_sense_gnd_lost_i(cond[6]), .boost_gate_short_i(cond[3]), .buck_switch_short_i(cond[2]),
      .buck_switch_open_i(cond[1]), .main_output_out_of_range_i(cond[0]),
      .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_hit_o(rd_hit_o));
   host_read_model host (.clock_i(clock_i), .rd_en_o(rd_en), .rd_addr_o(rd_addr));
   initial forever #50 clock_i = ~clock_i;
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : step
   task automatic rd(input logic [6:0] a, input logic [8:0] e);
      host.read(a);
      exp_q.push_back(e);
   endtask : rd
   function automatic logic [8:0] lvl();
      return {1'b1, test_pin_i, 1'b1, cfg_i, 4'h0, wake_i};
   endfunction : lvl
   task automatic check_read(input logic [8:0] e, input logic [8:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] rd_hit_o,rd_data_o expected %h seen %h", e, g);
      end
   endtask : check_read
   task automatic check_valid(input int e, input int g);
      compares++;
      if (g != e) begin
         bad_count++;
         $display("[FAIL] rd_valid_o count expected %0d seen %0d", e, g);
      end
   endtask : check_valid
   always @(negedge clock_i) begin
      if (rd_valid_o === 1'b1 && exp_q.size() == 0)
         check_valid(0, 1);
      else if (rd_valid_o === 1'b1)
         check_read(exp_q.pop_front(), {rd_hit_o, rd_data_o});
   end
   task automatic give_verdict();
      // every issued read must have been answered
      check_valid(0, exp_q.size());
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   initial begin
      #1000000;
      bad_count++;
      give_verdict();
   end
   initial begin
      logic [6:0] a;
      void'($urandom(32'h6fc8a08a));
      step(6);
      rst_i = 1'b0;
      repeat (6) begin
         {test_pin_i, wake_i, cfg_i} = 3'($urandom);
         step(2);
         rd(7'h48, lvl());
         host.idle();
      end
      rd(7'h7e, {1'b1, PL, VC});
      rd(7'h49, 9'h000);
      repeat (6) begin
         a = 7'($urandom);
         if (a != 7'h48 && a != 7'h4c && a != 7'h7e)
            rd(a, 9'h000);
      end
      host.idle();
      for (int i = 0; i < 10; i++) begin
         cond = 10'h001 << i;
         step(1);
         cond = 10'h000;
         rd(7'h4c, {1'b1, 8'h01 << bit_of[i]});
         rd(7'h4c, 9'h100);
         host.idle();
      end
      cond = 10'h019;
      rd(7'h4c, 9'h131);
      rd(7'h4c, 9'h131);
      host.idle();
      cond = 10'h000;
      cfg_i = 1'b1;
      soft_reset_i = 1'b1;
      // level read taken on the edge right after the soft reset edge
      rd(7'h48, {1'b1, test_pin_i, 2'b10, 4'h0, wake_i});
      soft_reset_i = 1'b0;
      rd(7'h4c, 9'h100);
      host.idle();
      cond = 10'h009;
      step(1);
      cond = 10'h000;
      restart_i = 1'b1;
      step(1);
      restart_i = 1'b0;
      rd(7'h4c, 9'h110);
      host.idle();
      cond = 10'h008;
      step(1);
      cond = 10'h000;
      rst_i = 1'b1;
      step(1);
      rst_i = 1'b0;
      step(2);
      rd(7'h4c, 9'h100);
      rd(7'h48, lvl());
      host.idle();
      step(3);
      give_verdict();
   end
endmodule : sbc_status_readback_regs_tb_top
`default_nettype wire
